// >>> hdl/modem_pkg.sv
// Shared constants for the modem status and baud pin block of one serial channel.
// Assumes a single 100 MHz clock and an 8-bit register port with a 4-bit address.
package modem_pkg;

  // Bus widths.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int EV_W = 3;

  // Register offsets on the plain register port.
  localparam logic [3:0] LINE_CONTROL_OFF = 4'h3;
  localparam logic [3:0] MODEM_CONTROL_OFF = 4'h4;
  localparam logic [3:0] MODEM_STATUS_OFF = 4'h6;
  localparam logic [3:0] TEST_CONFIG_OFF = 4'h8;
  localparam logic [3:0] EVENT_STATUS_OFF = 4'h9;
  localparam logic [3:0] EVENT_MASK_OFF = 4'hA;

  // Modem status byte layout.
  localparam int STAT_CTS_CHG_BIT = 0;
  localparam int STAT_DSR_CHG_BIT = 1;
  localparam int STAT_DCD_CHG_BIT = 3;
  localparam int STAT_CTS_BIT = 4;
  localparam int STAT_DSR_BIT = 5;
  localparam int STAT_DCD_BIT = 7;

  // Control field positions.
  localparam int LINE_DIV_ACCESS_BIT = 7;
  localparam int CTRL_DTR_BIT = 0;
  localparam int CTRL_RTS_BIT = 1;
  localparam int CTRL_OUT2_BIT = 3;
  localparam int CTRL_LOOP_BIT = 4;
  localparam int TEST_MODE_BIT = 0;

  // Index of each modem input in the level, change and event vectors.
  localparam int EV_CTS = 0;
  localparam int EV_DSR = 1;
  localparam int EV_DCD = 2;

  // Values after reset.
  localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
  localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
  localparam logic [7:0] TEST_CONFIG_RST = 8'h00;
  localparam logic [2:0] EV_RST = 3'h0;
  localparam logic [2:0] PIN_IDLE_RST = 3'h7;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic IDLE_HIGH_RST = 1'b1;

endpackage

// >>> hdl/modem_sync_if.sv
// Carries the synchronised modem input levels from the pin synchroniser to the core.
// Levels are active high: one means the modem asserts the line.
`timescale 1ns/1ps
`default_nettype none
interface modem_sync_if;
  logic cts_on;
  logic dsr_on;
  logic dcd_on;
  modport src(output cts_on, output dsr_on, output dcd_on);
  modport dst(input cts_on, input dsr_on, input dcd_on);
endinterface
`default_nettype wire

// >>> hdl/modem_pin_sync.sv
// Two-stage synchroniser for the three active-low modem status pins.
// Assumes the pins are asynchronous to mclk and idle high.
`timescale 1ns/1ps
`default_nettype none
module modem_pin_sync
  import modem_pkg::*;
(
  // Clock and control
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Raw pins, order cts, dsr, dcd
  input wire logic [2:0] pins_n,
  // Synchronised levels
  modem_sync_if.src lvl
);

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stable;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.meta = pins_n;
      st_nxt.stable = st_r.meta;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r.meta <= PIN_IDLE_RST;
      st_r.stable <= PIN_IDLE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only the second stage is looked at downstream.
  assign lvl.cts_on = ~st_r.stable[EV_CTS];
  assign lvl.dsr_on = ~st_r.stable[EV_DSR];
  assign lvl.dcd_on = ~st_r.stable[EV_DCD];

endmodule
`default_nettype wire

// >>> hdl/modem_status_top.sv
// Modem status, modem control and baud output pin logic of one serial channel.
// Assumes an 8-bit register port where read data follow the read strobe by one
// cycle, and a transmitter and baud generator that feed their outputs in on mclk.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Status bit 4 shows the inverse of the active-low clear-to-send pin, or modem control bit 1 in loopback.
// - Status bit 0 is set when clear-to-send changed since the last status read.
// - A newly set clear-to-send change raises the interrupt when enabled.
// - Clear-to-send never gates or alters the transmit output.
// - Status bit 7 shows the inverse of the active-low carrier-detect pin, or modem control bit 3 in loopback.
// - Status bit 3 is set when carrier-detect changed since the last status read.
// - A newly set carrier-detect change raises the interrupt when enabled.
// - The shared pin carries the baud clock only in test mode with divisor access set.
// - After reset the shared pin carries the serial transmit output.
// - Status bit 5 shows the inverse of the active-low data-set-ready pin, or modem control bit 0 in loopback.
// - Status bit 1 flags a data-set-ready change and raises the interrupt when enabled.
// - Modem control bit 0 drives terminal-ready low; reset and loopback hold it high.
module modem_status_top
  import modem_pkg::*;
(
  // Clock, reset and clock enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // Modem pins, active low
  input wire logic send_clear_n,
  input wire logic set_ready_n,
  input wire logic carrier_n,
  output logic terminal_ready_n,
  // Transmit path and shared pin
  input wire logic serial_transmit_out,
  input wire logic baud_gen_clk,
  output logic baud_clock_pin,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] test_config;
    logic [2:0] level;
    logic [2:0] changed;
    logic [2:0] ev_status;
    logic [2:0] ev_mask;
    logic [7:0] rdata;
    logic irq;
    logic terminal_ready_n;
    logic baud_clock_pin;
  } core_t;

  core_t st_r;
  core_t st_nxt;

  modem_sync_if sync_lvl();

  logic [2:0] pin_level;
  logic [2:0] loop_level;
  logic [2:0] level_now;
  logic [2:0] level_diff;
  logic loop_on;
  logic status_rd;
  logic [2:0] change_clr;
  logic [2:0] event_set;
  logic [2:0] event_clr;
  logic baud_sel;
  logic [7:0] rd_value;

  // True when the port addresses the register at off.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // A flag update in which a setting event wins over a clear in the same cycle.
  function automatic logic [2:0] set_wins(
    input logic [2:0] cur,
    input logic [2:0] set,
    input logic [2:0] clr
  );
    set_wins = (cur & ~clr) | set;
  endfunction

  // Builds the modem status byte from levels and change bits.
  function automatic logic [7:0] status_byte(input logic [2:0] lv, input logic [2:0] ch);
    logic [7:0] b;
    b = 8'h00;
    b[STAT_CTS_BIT] = lv[EV_CTS];
    b[STAT_DSR_BIT] = lv[EV_DSR];
    b[STAT_DCD_BIT] = lv[EV_DCD];
    b[STAT_CTS_CHG_BIT] = ch[EV_CTS];
    b[STAT_DSR_CHG_BIT] = ch[EV_DSR];
    b[STAT_DCD_CHG_BIT] = ch[EV_DCD];
    status_byte = b;
  endfunction

  // Pads a three-bit event vector to the data width.
  function automatic logic [7:0] ev_byte(input logic [2:0] v);
    ev_byte = {5'h00, v};
  endfunction

  modem_pin_sync u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .pins_n({carrier_n, set_ready_n, send_clear_n}),
    .lvl(sync_lvl)
  );

  // Synchronised pin levels, asserted high, which are the inverse of the pins.
  always_comb begin
    pin_level = 3'h0;
    pin_level[EV_CTS] = sync_lvl.cts_on;
    pin_level[EV_DSR] = sync_lvl.dsr_on;
    pin_level[EV_DCD] = sync_lvl.dcd_on;
  end

  // In loopback the status inputs follow the modem control outputs instead.
  always_comb begin
    loop_level = 3'h0;
    loop_level[EV_CTS] = st_r.modem_control[CTRL_RTS_BIT];
    loop_level[EV_DSR] = st_r.modem_control[CTRL_DTR_BIT];
    loop_level[EV_DCD] = st_r.modem_control[CTRL_OUT2_BIT];
  end

  assign loop_on = st_r.modem_control[CTRL_LOOP_BIT];
  assign level_now = loop_on ? loop_level : pin_level;

  // A change is any difference from the level seen one cycle earlier.
  assign level_diff = level_now ^ st_r.level;

  // A status read clears every change bit.
  assign status_rd = rd & hit(addr, MODEM_STATUS_OFF);
  assign change_clr = status_rd ? 3'h7 : 3'h0;

  // An event fires when a change bit goes from clear to set.
  assign event_set = level_diff & (~st_r.changed | change_clr);

  // Writing ones to the event status clears those bits.
  assign event_clr = (wr & hit(addr, EVENT_STATUS_OFF)) ? wdata[2:0] : 3'h0;

  // The baud clock is only routed out in test mode with divisor access set.
  assign baud_sel = st_r.test_config[TEST_MODE_BIT]
                  & st_r.line_control[LINE_DIV_ACCESS_BIT];

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    case (addr)
      LINE_CONTROL_OFF: begin
        rd_value = st_r.line_control;
      end
      MODEM_CONTROL_OFF: begin
        rd_value = st_r.modem_control;
      end
      MODEM_STATUS_OFF: begin
        rd_value = status_byte(st_r.level, st_r.changed);
      end
      TEST_CONFIG_OFF: begin
        rd_value = st_r.test_config;
      end
      EVENT_STATUS_OFF: begin
        rd_value = ev_byte(st_r.ev_status);
      end
      EVENT_MASK_OFF: begin
        rd_value = ev_byte(st_r.ev_mask);
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // Register writes.
      if (wr) begin
        if (hit(addr, LINE_CONTROL_OFF)) begin
          st_nxt.line_control = wdata;
        end
        if (hit(addr, MODEM_CONTROL_OFF)) begin
          st_nxt.modem_control = wdata;
        end
        if (hit(addr, TEST_CONFIG_OFF)) begin
          st_nxt.test_config = wdata;
        end
        if (hit(addr, EVENT_MASK_OFF)) begin
          st_nxt.ev_mask = wdata[2:0];
        end
      end

      // Level tracking and change bits; a change during the read survives it.
      st_nxt.level = level_now;
      st_nxt.changed = set_wins(st_r.changed, level_diff, change_clr);

      // Sticky events with write-one-to-clear, set winning.
      st_nxt.ev_status = set_wins(st_r.ev_status, event_set, event_clr);

      // Read data stand only in the cycle after the strobe.
      st_nxt.rdata = rd ? rd_value : 8'h00;

      // Mask gates the sticky events onto the interrupt line.
      st_nxt.irq = |(st_nxt.ev_status & st_nxt.ev_mask);

      // Terminal ready is driven low by the control bit, held high in loopback.
      st_nxt.terminal_ready_n = ~(st_nxt.modem_control[CTRL_DTR_BIT]
                                & ~st_nxt.modem_control[CTRL_LOOP_BIT]);

      // Shared pin: transmit data pass straight through, untouched by clear-to-send.
      st_nxt.baud_clock_pin = baud_sel ? baud_gen_clk : serial_transmit_out;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r.line_control <= LINE_CONTROL_RST;
      st_r.modem_control <= MODEM_CONTROL_RST;
      st_r.test_config <= TEST_CONFIG_RST;
      st_r.level <= EV_RST;
      st_r.changed <= EV_RST;
      st_r.ev_status <= EV_RST;
      st_r.ev_mask <= EV_RST;
      st_r.rdata <= RDATA_RST;
      st_r.irq <= 1'b0;
      st_r.terminal_ready_n <= IDLE_HIGH_RST;
      st_r.baud_clock_pin <= IDLE_HIGH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign terminal_ready_n = st_r.terminal_ready_n;
  assign baud_clock_pin = st_r.baud_clock_pin;
  assign irq = st_r.irq;

endmodule
`default_nettype wire

// >>> bench/modem_line_model.sv
// Behavioural modem driving the three active-low status pins.
// Assumes the bench sets the levels; a set bit asserts a pin.
`timescale 1ns/1ps
`default_nettype none
module modem_line_model (
  // Requested levels, order cts, dsr, dcd
  input wire logic [2:0] on,
  input wire logic slow,
  // Pins
  output var logic [2:0] pins_n
);
  // Pins move off the clock edge, late in the period when slow.
  initial begin
    pins_n = 3'h7;
    forever begin
      @(on);
      pins_n <= #(slow ? 7 : 2) ~on;
    end
  end
endmodule
`default_nettype wire

// >>> bench/modem_status_checker.sv
// Checker bound to the modem status top, watching its ports only.
// Assumes the package offsets; a low ce makes the properties vacuous, except a_rst_pin, a_cts_chg, a_dcd_chg, which need ce high after reset or at the read.
`timescale 1ns/1ps
`default_nettype none
module modem_status_checker
  import modem_pkg::*;
(
  // Bus
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  // Pins
  input wire logic send_clear_n,
  input wire logic set_ready_n,
  input wire logic carrier_n,
  input wire logic terminal_ready_n,
  input wire logic serial_transmit_out,
  input wire logic baud_gen_clk,
  input wire logic baud_clock_pin
);
  logic [2:0] pins_q;
  logic div_access_r, test_r, dtr_r;
  wire logic still = {send_clear_n, set_ready_n, carrier_n} == pins_q;
  wire logic st_rd = rd && addr == MODEM_STATUS_OFF;
  wire logic sel = div_access_r && test_r;
  always_ff @(posedge mclk) begin
    pins_q <= {send_clear_n, set_ready_n, carrier_n};
    if (!resetn) begin
      div_access_r <= 1'b0;
      test_r <= 1'b0;
      dtr_r <= 1'b1;
    end else if (ce && wr) begin
      if (addr == LINE_CONTROL_OFF)
        div_access_r <= wdata[LINE_DIV_ACCESS_BIT];
      if (addr == TEST_CONFIG_OFF)
        test_r <= wdata[TEST_MODE_BIT];
      if (addr == MODEM_CONTROL_OFF)
        dtr_r <= !(wdata[CTRL_DTR_BIT] && !wdata[CTRL_LOOP_BIT]);
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  property p_cts;
    (ce && still)[*5] ##0 st_rd |=> rdata[STAT_CTS_BIT] == !$past(send_clear_n);
  endproperty
  a_cts: assert property (p_cts) else $error("cts level");
  property p_dcd;
    (ce && still)[*5] ##0 st_rd |=> rdata[STAT_DCD_BIT] == !$past(carrier_n);
  endproperty
  a_dcd: assert property (p_dcd) else $error("dcd level");
  property p_cts_chg;
    $changed(send_clear_n) ##1 ((ce && still && !st_rd) throughout ##[4:30] 1'b1)
      ##1 st_rd |=> rdata[STAT_CTS_CHG_BIT];
  endproperty
  a_cts_chg: assert property (p_cts_chg) else $error("cts change");
  property p_dcd_chg;
    $changed(carrier_n) ##1 ((ce && still && !st_rd) throughout ##[4:30] 1'b1)
      ##1 st_rd |=> rdata[STAT_DCD_CHG_BIT];
  endproperty
  a_dcd_chg: assert property (p_dcd_chg) else $error("dcd change");
  property p_clr;
    (ce && still)[*4] ##0 st_rd ##1 (ce && still && st_rd) |=> rdata[3:0] == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("change kept");
  property p_dtr;
    ce && wr && addr == MODEM_CONTROL_OFF ##1 ce && !wr |=> terminal_ready_n == dtr_r;
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready");
  property p_mux;
    $past(ce && resetn && !wr) |->
      baud_clock_pin == $past(sel ? baud_gen_clk : serial_transmit_out);
  endproperty
  a_mux: assert property (p_mux) else $error("shared pin");
  property p_rst_pin;
    $rose(resetn) |=> baud_clock_pin == $past(serial_transmit_out);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("pin after reset");
endmodule
bind modem_status_top modem_status_checker chk (.mclk(mclk), .resetn(resetn), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .send_clear_n(send_clear_n), .set_ready_n(set_ready_n), .carrier_n(carrier_n),
  .terminal_ready_n(terminal_ready_n), .serial_transmit_out(serial_transmit_out),
  .baud_gen_clk(baud_gen_clk), .baud_clock_pin(baud_clock_pin));
`default_nettype wire

// >>> bench/modem_status_top_tb.sv
// Directed bench for the modem status block over its register port.
// Assumes the line model drives the pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module modem_status_top_tb
  import modem_pkg::*;
;
  logic mclk = 0, resetn = 0, ce = 1, wr = 0, rd = 0;
  logic sto = 0, sto_q = 0, bgc = 0, bgc_q = 0, slow = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0;
  logic [2:0] on = 0;
  wire logic [7:0] rdata;
  wire logic [2:0] pins_n;
  wire logic trdy_n, bpin, irq;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  modem_status_top dut (.mclk(mclk), .resetn(resetn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .send_clear_n(pins_n[0]),
    .set_ready_n(pins_n[1]), .carrier_n(pins_n[2]), .terminal_ready_n(trdy_n),
    .serial_transmit_out(sto), .baud_gen_clk(bgc), .baud_clock_pin(bpin), .irq(irq));
  modem_line_model line (.on(on), .slow(slow), .pins_n(pins_n));
  initial forever #5 mclk = ~mclk;
  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sto <= cyc[0] ^ cyc[2];
    bgc <= cyc[1];
    bgc_q <= bgc;
    sto_q <= sto;
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic rreg(input logic [3:0] a, input int n, input logic [7:0] e, input string nm);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    repeat (n) @(posedge mclk);
    rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  task automatic pin(input logic [2:0] v);
    on = v;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  // Follows the shared pin for eight cycles against the source it should carry.
  task automatic pin_out(input logic use_baud, input string nm);
    repeat (8) begin
      @(posedge mclk);
      #1 chk(nm, 8'(bpin), 8'(use_baud ? bgc_q : sto_q));
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    wreg(4'hF, 8'hFF);
    chk("trdy", 8'(trdy_n), 8'h01);
    rreg(4'hF, 1, 8'h00, "unmapped");
    rreg(MODEM_STATUS_OFF, 1, 8'h00, "status");
    rreg(TEST_CONFIG_OFF, 1, 8'h00, "test");
    wreg(EVENT_MASK_OFF, 8'h03);
    pin(3'h1);
    chk("irq", 8'(irq), 8'h01);
    rreg(EVENT_STATUS_OFF, 1, 8'h01, "event");
    rreg(MODEM_STATUS_OFF, 1, 8'h11, "status");
    rreg(MODEM_STATUS_OFF, 2, 8'h10, "status");
    wreg(EVENT_STATUS_OFF, 8'h01);
    chk("irq", 8'(irq), 8'h00);
    pin(3'h3);
    rreg(MODEM_STATUS_OFF, 1, 8'h32, "status");
    chk("irq", 8'(irq), 8'h01);
    wreg(EVENT_MASK_OFF, 8'h00);
    wreg(EVENT_STATUS_OFF, 8'h07);
    slow = 1'b1;
    pin(3'h7);
    chk("irq", 8'(irq), 8'h00);
    rreg(MODEM_STATUS_OFF, 1, 8'hB8, "status");
    wreg(EVENT_MASK_OFF, 8'h04);
    chk("irq", 8'(irq), 8'h01);
    wreg(LINE_CONTROL_OFF, 8'h80);
    wreg(TEST_CONFIG_OFF, 8'h01);
    // A write while the clock enable is low must leave the register alone.
    @(posedge mclk);
    ce <= 1'b0;
    wreg(LINE_CONTROL_OFF, 8'h00);
    @(posedge mclk);
    ce <= 1'b1;
    rreg(LINE_CONTROL_OFF, 1, 8'h80, "frozen");
    pin(3'h6);
    chk("baud", 8'(bpin), 8'(bgc_q));
    pin_out(1'b1, "baud");
    rreg(MODEM_STATUS_OFF, 1, 8'hA1, "status");
    wreg(MODEM_CONTROL_OFF, 8'h01);
    chk("trdy", 8'(trdy_n), 8'h00);
    wreg(MODEM_CONTROL_OFF, 8'h11);
    chk("trdy", 8'(trdy_n), 8'h01);
    wreg(MODEM_CONTROL_OFF, 8'h01);
    chk("trdy", 8'(trdy_n), 8'h00);
    // Reset in mid-run with the baud clock routed out and two modem lines asserted.
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    chk("trdy", 8'(trdy_n), 8'h01);
    chk("irq", 8'(irq), 8'h00);
    on = 3'h7;
    pin_out(1'b0, "txd");
    rreg(MODEM_STATUS_OFF, 1, 8'hBB, "status");
    end_of_test();
  end
endmodule
`default_nettype wire
